// ---- bench/dprs_sva.sv ----
`include "dprs_cfg.svh"
`default_nettype none

// ----
// port checker
// ----
module dprs_sva (
    input wire logic                  i_clk,
    input wire logic                  i_srst,
    input wire logic [15:0]           i_reg_addr,
    input wire logic                  i_reg_wr,
    input wire logic [7:0]            i_reg_wdata,
    input wire logic [3:0]            i_los,
    input wire logic [1:0]            i_gpio_sel,
    input wire logic [1:0]            i_phase_slope_limit,
    input wire dprs_pkg::dprs_ref_t   o_active_ref,
    input wire dprs_pkg::dprs_state_t o_pll_state,
    input wire logic                  o_fb_external,
    input wire dprs_pkg::dprs_ref_t   o_fb_ref,
    input wire logic                  o_phase_absorb,
    input wire logic                  o_slope_limit_en,
    input wire logic [6:0]            o_slope_rate_us
);
    import dprs_pkg::*;
    logic [7:0] mode_reg, mode_next;
    logic [1:0] frc_reg, frc_next;

    // mirror of mode byte and state force, since outputs lag writes
    always_comb begin
        mode_next = mode_reg;
        frc_next  = frc_reg;
        if (i_srst) begin
            mode_next = `DPRS_RST_MODE;
            frc_next  = `DPRS_RST_FORCE;
        end else if (i_reg_wr && i_reg_addr == `DPRS_ADDR_MODE) begin
            mode_next = i_reg_wdata;
        end else if (i_reg_wr && i_reg_addr == `DPRS_ADDR_EXCL) begin
            frc_next = i_reg_wdata[1:0];
        end
    end

    // mirror registers
    always_ff @(posedge i_clk) begin
        mode_reg <= mode_next;
        frc_reg  <= frc_next;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    // first edge after reset still shows reset outputs, hence the past guard
    property p_fb;
        !$past(i_srst) |-> o_fb_external == $past(mode_reg[4])
            && (!o_fb_external || o_fb_ref == $past(mode_reg[3:2]));
    endproperty
    a_fb: assert property (p_fb) else $error("feedback source wrong");
    property p_absorb;
        !$past(i_srst) |-> o_phase_absorb == !$past(mode_reg[0]);
    endproperty
    a_absorb: assert property (p_absorb) else $error("phase absorb wrong");
    property p_slen;
        !$past(i_srst) |-> o_slope_limit_en == ($past(mode_reg[0])
            && ($past(i_phase_slope_limit) == 2'h1 || $past(i_phase_slope_limit) == 2'h2));
    endproperty
    a_slen: assert property (p_slen) else $error("slope enable wrong");
    property p_rate;
        o_slope_limit_en |-> o_slope_rate_us == ($past(i_phase_slope_limit) == 2'h1
            ? `DPRS_RATE_83_US : `DPRS_RATE_13_US);
    endproperty
    a_rate: assert property (p_rate) else $error("slope rate wrong");
    property p_rate0;
        !o_slope_limit_en |-> o_slope_rate_us == 7'h00;
    endproperty
    a_rate0: assert property (p_rate0) else $error("rate without limit");
    property p_forced;
        !$past(i_srst) && $past(mode_reg[7]) && $past(frc_reg) == 2'h0
            && !$past(i_los[mode_reg[6:5]]) |-> o_active_ref == $past(mode_reg[6:5]);
    endproperty
    a_forced: assert property (p_forced) else $error("forced ref wrong");
    property p_gpio;
        !$past(i_srst) && $past(mode_reg[7:5]) == 3'h1 && $past(frc_reg) == 2'h0
            && !$past(i_los[i_gpio_sel]) |-> o_active_ref == $past(i_gpio_sel);
    endproperty
    a_gpio: assert property (p_gpio) else $error("pin ref wrong");
    property p_state;
        !$past(i_srst) && $past(frc_reg) != 2'h0
            |-> o_pll_state == (3'b001 << ($past(frc_reg) - 2'h1));
    endproperty
    a_state: assert property (p_state) else $error("forced state wrong");
endmodule

bind dprs_ctrl dprs_sva u_sva (.i_clk(i_clk), .i_srst(i_srst), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_los(i_los), .i_gpio_sel(i_gpio_sel),
    .i_phase_slope_limit(i_phase_slope_limit), .o_active_ref(o_active_ref),
    .o_pll_state(o_pll_state), .o_fb_external(o_fb_external), .o_fb_ref(o_fb_ref),
    .o_phase_absorb(o_phase_absorb), .o_slope_limit_en(o_slope_limit_en),
    .o_slope_rate_us(o_slope_rate_us));

`default_nettype wire

// ---- bench/testbench.sv ----
`include "dprs_cfg.svh"
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import dprs_pkg::*;
    typedef struct {int kind; logic [31:0] exp; int due;} dprs_note_t;
    logic         clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, valid, fbx, absorb, slen, en;
    logic [15:0]  addr = 16'h0000, base;
    logic [7:0]   wdata = 8'h00, rdata, pr, m;
    logic [3:0]   los = 4'h0, ex, ls, nb;
    logic [1:0]   gsel = 2'h0, slope = 2'h0, r;
    logic [6:0]   rate;
    dprs_ref_t    act, fbr;
    dprs_state_t  st;
    dprs_prediv_t pre, pv;
    dprs_note_t   notes[$];
    string        nm[5] = '{"rdata", "select", "prediv", "state", "fbslope"};
    int           n_mismatch = 0, num_checks = 0, cyc = 0, seed = 87980;

    dprs_ctrl DUT (.i_clk(clk), .i_srst(srst), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_los(los),
        .i_gpio_sel(gsel), .i_phase_slope_limit(slope), .o_active_ref(act),
        .o_ref_valid(valid), .o_pll_state(st), .o_fb_external(fbx), .o_fb_ref(fbr),
        .o_predivider(pre), .o_phase_absorb(absorb), .o_slope_limit_en(slen),
        .o_slope_rate_us(rate));

    // 50 MHz clock and cycle count
    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    function automatic logic [31:0] seen(input int k);
        case (k)
            0: seen = {24'h0, rdata};
            1: seen = {26'h0, valid, act, st};
            2: seen = {11'h0, pre};
            3: seen = {29'h0, st};
            default: seen = {20'h0, fbx, fbr, absorb, slen, rate};
        endcase
    endfunction

    // best usable reference; strict compare lets the lower index win ties
    function automatic logic [1:0] best(input logic [7:0] p, input logic [3:0] bad);
        logic [2:0] lo;
        best = 2'h0;
        lo = 3'h4;
        for (int k = 0; k < 4; k++) begin
            if (!bad[k] && {1'b0, p[2*k +: 2]} < lo) begin
                lo = {1'b0, p[2*k +: 2]};
                best = 2'(k);
            end
        end
    endfunction

    // one bus cycle, changed just after the edge
    task automatic bus(input logic w, input logic q, input logic [15:0] a, input logic [7:0] d);
        wr = w;
        rd = q;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1;
    endtask

    task automatic want(input int k, input logic [31:0] e, input int d);
        notes.push_back('{k, e, cyc + d});
    endtask

    task automatic wreg(input logic [15:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask

    task automatic rreg(input logic [15:0] a, input logic [7:0] e);
        want(0, {24'h0, e}, 1);
        bus(1'b0, 1'b1, a, 8'h00);
    endtask

    // settle a few cycles, then check one steady output group
    task automatic chk(input int k, input logic [31:0] e);
        repeat (3) bus(1'b0, 1'b0, 16'h0000, 8'h00);
        want(k, e, 1);
        bus(1'b0, 1'b0, 16'h0000, 8'h00);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // monitor: oldest note is compared once its cycle has come
    initial forever begin
        @(posedge clk);
        #2;
        while (notes.size() > 0 && notes[0].due <= cyc) begin
            num_checks++;
            if (seen(notes[0].kind) !== notes[0].exp) begin
                n_mismatch++;
                $display("[ERR] %s exp %h seen %h", nm[notes[0].kind], notes[0].exp,
                    seen(notes[0].kind));
            end
            void'(notes.pop_front());
        end
    end

    // watchdog, about twenty times the expected run
    initial begin
        #(8000 * 20);
        n_mismatch++;
        summarize();
    end

    initial begin
        repeat (4) @(posedge clk);
        #1;
        srst = 1'b0;
        rreg(`DPRS_ADDR_MODE, 8'h03);
        rreg(`DPRS_ADDR_PRIO, 8'hE4);
        rreg(`DPRS_ADDR_EXCL, 8'h00);
        for (int a = 16'h3E; a <= 16'h49; a++) rreg(16'(a), 8'h00);
        rreg(16'h004A, 8'h00);
        chk(1, {26'h0, 1'b1, 2'h0, DPRS_ST_NORM});
        los = 4'h1;
        chk(1, {26'h0, 1'b1, 2'h1, DPRS_ST_NORM});
        los = 4'hF;
        chk(1, {26'h0, 1'b0, 2'h1, DPRS_ST_HOLD});
        los = 4'h0;
        chk(1, {26'h0, 1'b1, 2'h0, DPRS_ST_NORM});
        // random priorities, exclusions and losses; one reference always usable
        for (int n = 0; n < 24; n++) begin
            pr = 8'($random(seed));
            ex = 4'($random(seed));
            ls = 4'($random(seed));
            if ((ex | ls) == 4'hF) begin
                ex[n % 4] = 1'b0;
                ls[n % 4] = 1'b0;
            end
            wreg(`DPRS_ADDR_PRIO, pr);
            wreg(`DPRS_ADDR_EXCL, {ex, 4'h0});
            los = ls;
            chk(1, {26'h0, 1'b1, best(pr, ex | ls), DPRS_ST_NORM});
        end
        // clear losses first so revertive choice settles on reference 0 before the switch
        los = 4'h0;
        wreg(`DPRS_ADDR_PRIO, 8'hE4);
        wreg(`DPRS_ADDR_EXCL, 8'h00);
        wreg(`DPRS_ADDR_MODE, 8'h01);
        los = 4'h1;
        chk(1, {26'h0, 1'b1, 2'h1, DPRS_ST_NORM});
        los = 4'h0;
        chk(1, {26'h0, 1'b1, 2'h1, DPRS_ST_NORM});
        // every selection code, reserved ones behaving as automatic
        for (int c = 0; c < 8; c++) begin
            gsel = 2'($random(seed));
            wreg(`DPRS_ADDR_MODE, {3'(c), 5'h03});
            r = (c >= 4) ? 2'(c) : ((c == 1) ? gsel : 2'h0);
            chk(1, {26'h0, 1'b1, r, DPRS_ST_NORM});
        end
        wreg(`DPRS_ADDR_MODE, 8'h03);
        for (int f = 1; f < 4; f++) begin
            wreg(`DPRS_ADDR_EXCL, {6'h0, 2'(f)});
            chk(3, {29'h0, 3'b001 << (f - 1)});
        end
        wreg(`DPRS_ADDR_EXCL, 8'h00);
        chk(1, {26'h0, 1'b1, 2'h0, DPRS_ST_NORM});
        // feedback codes, phase policy and slope codes
        for (int n = 0; n < 16; n++) begin
            nb = 4'(n);
            slope = nb[1:0];
            m = {3'h0, nb[2:0], 1'b1, nb[3]};
            wreg(`DPRS_ADDR_MODE, m);
            en = nb[3] && (nb[1:0] == 2'h1 || nb[1:0] == 2'h2);
            chk(4, {20'h0, m[4], m[3:2], !m[0], en,
                en ? (nb[0] ? `DPRS_RATE_83_US : `DPRS_RATE_13_US) : 7'h00});
        end
        // pre-divider bytes per reference, seen when that reference is forced
        for (int k = 0; k < 4; k++) begin
            pv = 21'($random(seed));
            base = `DPRS_ADDR_PRE_BASE + 16'(3 * k);
            wreg(base, {3'h0, pv[20:16]});
            wreg(base + 16'h1, pv[15:8]);
            wreg(base + 16'h2, pv[7:0]);
            rreg(base, {3'h0, pv[20:16]});
            rreg(base + 16'h1, pv[15:8]);
            rreg(base + 16'h2, pv[7:0]);
            wreg(`DPRS_ADDR_MODE, {1'b1, 2'(k), 5'h03});
            chk(2, {11'h0, pv});
        end
        repeat (3) bus(1'b0, 1'b0, 16'h0000, 8'h00);
        summarize();
    end
endmodule

`default_nettype wire

// ---- design/dprs_cfg.svh ----
`ifndef DPRS_CFG_SVH
`define DPRS_CFG_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define DPRS_ADDR_MODE      16'h003B
`define DPRS_ADDR_PRIO      16'h003C
`define DPRS_ADDR_EXCL      16'h003D
`define DPRS_ADDR_PRE_BASE  16'h003E
`define DPRS_PRE_STRIDE     16'h0003

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define DPRS_MODE_REFSEL_HI 7
`define DPRS_MODE_REFSEL_LO 5
`define DPRS_MODE_FBSEL_HI  4
`define DPRS_MODE_FBSEL_LO  2
`define DPRS_MODE_RVRT_BIT  1
`define DPRS_MODE_SWM_BIT   0
`define DPRS_EXCL_LO        4
`define DPRS_PRE_HI_BITS    5

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DPRS_RST_MODE       8'h03
`define DPRS_RST_PRIO       8'hE4
`define DPRS_RST_EXCL       4'h0
`define DPRS_RST_FORCE      2'h0
`define DPRS_RST_PRE        21'h000000

// ----------------------------------------------------------------------
// field codes
// ----------------------------------------------------------------------
`define DPRS_SEL_AUTO       3'h0
`define DPRS_SEL_GPIO       3'h1
`define DPRS_FORCE_AUTO     2'h0
`define DPRS_FORCE_FREE     2'h1
`define DPRS_FORCE_NORM     2'h2
`define DPRS_FORCE_HOLD     2'h3
`define DPRS_SLOPE_NONE     2'h0
`define DPRS_SLOPE_83       2'h1
`define DPRS_SLOPE_13       2'h2
`define DPRS_RATE_83_US     7'h53
`define DPRS_RATE_13_US     7'h0D

`endif

// ---- design/dprs_ctrl.sv ----
// Function
// - 000 automatic, 001 gpio, 010/011 reserved
// - codes 100-111 force reference 0-3
// - feedback codes 000-011 use internal divider
// - feedback codes 100-111 use external reference
// - revert bit: 0 non-revertive, 1 revertive
// - phase policy 0 absorbs phase offset
// - phase policy 1 caps slope, reset set
// - two-bit priority per reference, 00 highest
// - reset priorities 00, 01, 10, 11
// - exclusion bit removes reference from switchover
// - state control: auto, free, normal, holdover
// - 21-bit pre-divider per reference, reset zero
// - slope codes: none, 83, 13, reserved
`include "dprs_cfg.svh"
`default_nettype none

module dprs_ctrl (
    input  wire logic                  i_clk,
    input  wire logic                  i_srst,
    input  wire logic [15:0]           i_reg_addr,
    input  wire logic                  i_reg_wr,
    input  wire logic [7:0]            i_reg_wdata,
    input  wire logic                  i_reg_rd,
    output var  logic [7:0]            o_reg_rdata,
    input  wire logic [3:0]            i_los,
    input  wire logic [1:0]            i_gpio_sel,
    input  wire logic [1:0]            i_phase_slope_limit,
    output var  dprs_pkg::dprs_ref_t   o_active_ref,
    output var  logic                  o_ref_valid,
    output var  dprs_pkg::dprs_state_t o_pll_state,
    output var  logic                  o_fb_external,
    output var  dprs_pkg::dprs_ref_t   o_fb_ref,
    output var  dprs_pkg::dprs_prediv_t o_predivider,
    output var  logic                  o_phase_absorb,
    output var  logic                  o_slope_limit_en,
    output var  logic [6:0]            o_slope_rate_us
);
    import dprs_pkg::*;

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    logic [7:0]   mode_reg;
    logic [7:0]   mode_next;
    logic [7:0]   prio_reg;
    logic [7:0]   prio_next;
    logic [3:0]   excl_reg;
    logic [3:0]   excl_next;
    logic [1:0]   force_reg;
    logic [1:0]   force_next;
    dprs_prediv_t pre_reg  [4];
    dprs_prediv_t pre_next [4];
    logic [7:0]   rdata_reg;
    logic [7:0]   rdata_next;

    // byte address of the top byte of reference k's pre-divider
    function automatic logic [15:0] pre_addr(input int k);
        pre_addr = 16'(`DPRS_ADDR_PRE_BASE + k * `DPRS_PRE_STRIDE);
    endfunction

    // write decode; reserved bit positions are simply not stored
    always_comb begin
        mode_next  = mode_reg;
        prio_next  = prio_reg;
        excl_next  = excl_reg;
        force_next = force_reg;
        for (int k = 0; k < 4; k++) begin
            pre_next[k] = pre_reg[k];
        end
        if (i_reg_wr) begin
            case (i_reg_addr)
                `DPRS_ADDR_MODE: begin
                    mode_next = i_reg_wdata;
                end
                `DPRS_ADDR_PRIO: begin
                    prio_next = i_reg_wdata;
                end
                `DPRS_ADDR_EXCL: begin
                    excl_next  = i_reg_wdata[7:`DPRS_EXCL_LO];
                    force_next = i_reg_wdata[1:0];
                end
                default: begin
                end
            endcase
            for (int k = 0; k < 4; k++) begin
                if (i_reg_addr == pre_addr(k)) begin
                    pre_next[k][20:16] = i_reg_wdata[`DPRS_PRE_HI_BITS-1:0];
                end
                if (i_reg_addr == 16'(pre_addr(k) + 16'h0001)) begin
                    pre_next[k][15:8] = i_reg_wdata;
                end
                if (i_reg_addr == 16'(pre_addr(k) + 16'h0002)) begin
                    pre_next[k][7:0] = i_reg_wdata;
                end
            end
        end
    end

    // reset values give revertive switching and slope-capped switchover
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mode_reg  <= `DPRS_RST_MODE;
            prio_reg  <= `DPRS_RST_PRIO;
            excl_reg  <= `DPRS_RST_EXCL;
            force_reg <= `DPRS_RST_FORCE;
            for (int k = 0; k < 4; k++) begin
                pre_reg[k] <= `DPRS_RST_PRE;
            end
        end else begin
            mode_reg  <= mode_next;
            prio_reg  <= prio_next;
            excl_reg  <= excl_next;
            force_reg <= force_next;
            for (int k = 0; k < 4; k++) begin
                pre_reg[k] <= pre_next[k];
            end
        end
    end

    // ------------------------------------------------------------------
    // read back
    // ------------------------------------------------------------------
    // reserved bits read as zero; unmapped addresses read zero
    always_comb begin
        rdata_next = rdata_reg;
        if (i_reg_rd) begin
            rdata_next = 8'h00;
            case (i_reg_addr)
                `DPRS_ADDR_MODE: begin
                    rdata_next = mode_reg;
                end
                `DPRS_ADDR_PRIO: begin
                    rdata_next = prio_reg;
                end
                `DPRS_ADDR_EXCL: begin
                    rdata_next = {excl_reg, 2'h0, force_reg};
                end
                default: begin
                end
            endcase
            for (int k = 0; k < 4; k++) begin
                if (i_reg_addr == pre_addr(k)) begin
                    rdata_next = {3'h0, pre_reg[k][20:16]};
                end
                if (i_reg_addr == 16'(pre_addr(k) + 16'h0001)) begin
                    rdata_next = pre_reg[k][15:8];
                end
                if (i_reg_addr == 16'(pre_addr(k) + 16'h0002)) begin
                    rdata_next = pre_reg[k][7:0];
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // automatic candidate search
    // ------------------------------------------------------------------
    dprs_pick_if pick_bus ();

    assign pick_bus.prio = prio_reg;
    assign pick_bus.excl = excl_reg;
    assign pick_bus.los  = i_los;

    dprs_ref_pick u_pick (
        .pk (pick_bus.pick)
    );

    // ------------------------------------------------------------------
    // reference selection and pll state
    // ------------------------------------------------------------------
    dprs_ref_t   active_reg;
    dprs_ref_t   active_next;
    logic        valid_reg;
    logic        valid_next;
    dprs_state_t state_reg;
    dprs_state_t state_next;
    logic [2:0]  refsel;
    dprs_ref_t   cand;
    logic        cand_ok;
    logic        cur_ok;

    assign refsel = mode_reg[`DPRS_MODE_REFSEL_HI:`DPRS_MODE_REFSEL_LO];

    // the present reference stays usable while clean and not excluded
    assign cur_ok = valid_reg && !i_los[active_reg] && !excl_reg[active_reg];

    // manual modes ignore exclusion: it only shapes the auto sequence
    always_comb begin
        cand    = active_reg;
        cand_ok = 1'b0;
        if (refsel[2]) begin
            cand    = refsel[1:0];
            cand_ok = !i_los[refsel[1:0]];
        end else if (refsel == `DPRS_SEL_GPIO) begin
            cand    = i_gpio_sel;
            cand_ok = !i_los[i_gpio_sel];
        end else if (!mode_reg[`DPRS_MODE_RVRT_BIT] && cur_ok) begin
            cand    = active_reg;
            cand_ok = 1'b1;
        end else begin
            // auto and the reserved codes; revertive always takes the best
            cand    = pick_bus.best;
            cand_ok = pick_bus.found;
        end
    end

    // holdover keeps the last reference so a return is seamless
    always_comb begin
        active_next = cand_ok ? cand : active_reg;
        valid_next  = cand_ok;
        state_next  = state_reg;
        unique case (force_reg)
            `DPRS_FORCE_FREE: begin
                state_next = DPRS_ST_FREE;
            end
            `DPRS_FORCE_NORM: begin
                state_next = DPRS_ST_NORM;
            end
            `DPRS_FORCE_HOLD: begin
                state_next = DPRS_ST_HOLD;
            end
            `DPRS_FORCE_AUTO: begin
                unique case (state_reg)
                    DPRS_ST_FREE: begin
                        if (cand_ok) begin
                            state_next = DPRS_ST_NORM;
                        end
                    end
                    DPRS_ST_NORM: begin
                        if (!cand_ok) begin
                            state_next = DPRS_ST_HOLD;
                        end
                    end
                    DPRS_ST_HOLD: begin
                        if (cand_ok) begin
                            state_next = DPRS_ST_NORM;
                        end
                    end
                endcase
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            active_reg <= 2'h0;
            valid_reg  <= 1'b0;
            state_reg  <= DPRS_ST_FREE;
        end else begin
            active_reg <= active_next;
            valid_reg  <= valid_next;
            state_reg  <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    logic         fbx_next;
    dprs_ref_t    fbr_next;
    logic         absorb_next;
    logic         slope_en_next;
    logic [6:0]   rate_next;
    logic         fbx_reg;
    dprs_ref_t    fbr_reg;
    logic         absorb_reg;
    logic         slope_en_reg;
    logic [6:0]   rate_reg;
    dprs_prediv_t prediv_reg;

    // slope decode only matters when the policy asks for capping
    always_comb begin
        fbx_next      = mode_reg[`DPRS_MODE_FBSEL_HI];
        fbr_next      = mode_reg[`DPRS_MODE_FBSEL_HI-1:`DPRS_MODE_FBSEL_LO];
        absorb_next   = !mode_reg[`DPRS_MODE_SWM_BIT];
        slope_en_next = 1'b0;
        rate_next     = 7'h00;
        if (mode_reg[`DPRS_MODE_SWM_BIT]) begin
            unique case (i_phase_slope_limit)
                `DPRS_SLOPE_83: begin
                    slope_en_next = 1'b1;
                    rate_next     = `DPRS_RATE_83_US;
                end
                `DPRS_SLOPE_13: begin
                    slope_en_next = 1'b1;
                    rate_next     = `DPRS_RATE_13_US;
                end
                default: begin
                    // none or reserved: bandwidth alone sets the slope
                    slope_en_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            fbx_reg      <= 1'b0;
            fbr_reg      <= 2'h0;
            absorb_reg   <= 1'b0;
            slope_en_reg <= 1'b0;
            rate_reg     <= 7'h00;
            prediv_reg   <= `DPRS_RST_PRE;
        end else begin
            fbx_reg      <= fbx_next;
            fbr_reg      <= fbr_next;
            absorb_reg   <= absorb_next;
            slope_en_reg <= slope_en_next;
            rate_reg     <= rate_next;
            prediv_reg   <= pre_reg[active_next];
        end
    end

    assign o_reg_rdata      = rdata_reg;
    assign o_active_ref     = active_reg;
    assign o_ref_valid      = valid_reg;
    assign o_pll_state      = state_reg;
    assign o_fb_external    = fbx_reg;
    assign o_fb_ref         = fbr_reg;
    assign o_predivider     = prediv_reg;
    assign o_phase_absorb   = absorb_reg;
    assign o_slope_limit_en = slope_en_reg;
    assign o_slope_rate_us  = rate_reg;
endmodule

`default_nettype wire

// ---- design/dprs_pick_if.sv ----
`default_nettype none

// carries candidate data to the priority picker and its choice back
interface dprs_pick_if;
    logic [7:0] prio;
    logic [3:0] excl;
    logic [3:0] los;
    logic [1:0] best;
    logic       found;

    modport ctrl (output prio, output excl, output los, input best, input found);
    modport pick (input prio, input excl, input los, output best, output found);
endinterface

`default_nettype wire

// ---- design/dprs_pkg.sv ----
`default_nettype none

package dprs_pkg;
    // one-hot pll operating state
    typedef enum logic [2:0] {
        DPRS_ST_FREE = 3'b001,
        DPRS_ST_NORM = 3'b010,
        DPRS_ST_HOLD = 3'b100
    } dprs_state_t;

    typedef logic [20:0] dprs_prediv_t;
    typedef logic [1:0]  dprs_ref_t;
endpackage

`default_nettype wire

// ---- design/dprs_ref_pick.sv ----
`default_nettype none

module dprs_ref_pick (
    dprs_pick_if.pick pk
);
    // ------------------------------------------------------------------
    // priority search
    // ------------------------------------------------------------------
    // lowest code wins; ties go to the lower reference index
    always_comb begin
        logic [1:0] best_v;
        logic [1:0] code_v;
        logic       found_v;
        best_v  = 2'h0;
        code_v  = 2'h3;
        found_v = 1'b0;
        for (int k = 0; k < 4; k++) begin
            if (!pk.excl[k] && !pk.los[k]) begin
                if (!found_v || (pk.prio[2*k +: 2] < code_v)) begin
                    best_v  = 2'(k);
                    code_v  = pk.prio[2*k +: 2];
                    found_v = 1'b1;
                end
            end
        end
        pk.best  = best_v;
        pk.found = found_v;
    end
endmodule

`default_nettype wire
